// File: dcf_regs.svh
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// Data path and depth
`define DCF_DATA_W 36
`define DCF_AW_DEFAULT 10
`define DCF_AW_MID 12
`define DCF_AW_BIG 16
`define DCF_OFS_W 17

// Register stages behind the flags
`define DCF_FLAG_STAGES 2
`define DCF_NE_STAGES 2

// Default offsets, depths 1,024 and 2,048
`define DCF_OFS_S_0 17'h0007f
`define DCF_OFS_S_1 17'h000ff
`define DCF_OFS_S_2 17'h001ff
`define DCF_OFS_S_3 17'h0003f
`define DCF_OFS_S_4 17'h0001f
`define DCF_OFS_S_5 17'h00007
`define DCF_OFS_S_6 17'h0000f
`define DCF_OFS_S_7 17'h00003

// Default offsets, depths 4,096 to 32,768
`define DCF_OFS_M_0 17'h0007f
`define DCF_OFS_M_1 17'h000ff
`define DCF_OFS_M_2 17'h001ff
`define DCF_OFS_M_3 17'h0003f
`define DCF_OFS_M_4 17'h003ff
`define DCF_OFS_M_5 17'h0000f
`define DCF_OFS_M_6 17'h0001f
`define DCF_OFS_M_7 17'h00007

// Default offsets, depths 65,536 and 131,072
`define DCF_OFS_L_0 17'h0007f
`define DCF_OFS_L_1 17'h01fff
`define DCF_OFS_L_2 17'h03fff
`define DCF_OFS_L_3 17'h00fff
`define DCF_OFS_L_4 17'h003ff
`define DCF_OFS_L_5 17'h001ff
`define DCF_OFS_L_6 17'h007ff
`define DCF_OFS_L_7 17'h000ff

`endif

// File: dcf_pkg.sv
`include "dcf_regs.svh"

package dcf_pkg;
	typedef enum logic {
		DCF_STANDARD,
		DCF_FALL_THROUGH
	} dcf_mode_t;

	typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
endpackage

// File: dcf_mem_if.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"

interface dcf_mem_if #(
	parameter int unsigned AW = `DCF_AW_DEFAULT
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	dcf_pkg::dcf_word_t wr_data;
	logic [AW-1:0] rd_addr;
	dcf_pkg::dcf_word_t rd_data;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		input rd_data
	);

	modport mem (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_addr,
		output rd_data
	);
endinterface

// File: dcf_store.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_store #(
	parameter int unsigned AW = `DCF_AW_DEFAULT
) (
	// Clock
	input wire logic clk_i,
	// Memory port
	dcf_mem_if.mem m
);
	// Contents need no reset; flags gate every read
	dcf_pkg::dcf_word_t store [0:(1 << AW)-1];

	always_ff @(posedge clk_i) begin
		if (m.wr_en) begin
			store[m.wr_addr] <= m.wr_data;
		end
	end

	assign m.rd_data = store[m.rd_addr];
endmodule

// File: dcf_stage_pipe.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_stage_pipe #(
	parameter int unsigned STAGES = `DCF_FLAG_STAGES,
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Level in and delayed level out
	input wire logic d_i,
	output logic q_o
);
	logic [STAGES-1:0] sh_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_reg <= {STAGES{RESET_VAL}};
		end else begin
			sh_reg <= {sh_reg[STAGES-2:0], d_i};
		end
	end

	assign q_o = sh_reg[STAGES-1];
endmodule

// File: dcf_fifo.sv
// Overview of operation
// - Mode pin low at reset selects standard mode with empty and full flags.
// - Mode pin high at reset selects fall-through mode, output-ready and space.
// - Fall-through: first word reaches outputs after three edges, no read enable.
// - Write enable low captures data in on the clock edge, either mode.
// - Standard mode empty flag goes high after first write into empty buffer.
// - Standard mode almost-empty goes high once n + 1 words are held.
// - Standard mode half-full goes low at half the depth plus one.
// - Standard mode almost-full goes low at depth minus m words.
// - Standard mode full goes low at depth words; first read returns it high.
// - Almost-full and half-full release at the same thresholds while draining.
// - Standard mode almost-empty goes low when n words remain.
// - Standard mode empty goes low on last read; reads ignored while empty.
// - Standard mode empty and full flags each pass two register stages.
// - Fall-through output-ready goes low after first word into empty buffer.
// - Fall-through almost-empty goes high once n + 2 words are held.
// - Fall-through half-full goes low at half the depth plus two.
// - Fall-through almost-full goes low at depth plus one minus m words.
// - Fall-through write-space goes high at depth plus one words.
// - Fall-through first read from full drops space; almost-empty low at n + 1.
// - Fall-through output-ready goes high on last read; reads then ignored.
// - Output-ready passes three register stages, write-space two.
// - Reset loads one of eight default offsets from load and select pins.
`timescale 1ns/1ps
`include "dcf_regs.svh"

module dcf_fifo #(
	parameter int unsigned AW = `DCF_AW_DEFAULT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Writer side
	input wire logic wr_en_n_i,
	input wire logic [`DCF_DATA_W-1:0] data_in_i,
	// Reader side
	input wire logic rd_en_n_i,
	output logic [`DCF_DATA_W-1:0] data_out_o,
	// Straps sampled during reset
	input wire logic timing_mode_serial_in_i,
	input wire logic load_select_i,
	input wire logic offset_select_0_i,
	input wire logic offset_select_1_i,
	// Standard mode flags
	output logic empty_indicator_n_o,
	output logic full_indicator_n_o,
	// Fall-through mode flags
	output logic output_ready_n_o,
	output logic write_space_n_o,
	// Occupancy flags
	output logic almost_empty_indicator_n_o,
	output logic almost_full_indicator_n_o,
	output logic half_full_indicator_n_o
);
	localparam logic [AW:0] DEPTH_C = {1'b1, {AW{1'b0}}};
	localparam logic [AW:0] HALF_C = DEPTH_C >> 1;
	localparam logic [AW:0] ONE_C = {{AW{1'b0}}, 1'b1};

	function automatic logic [`DCF_OFS_W-1:0] default_offset(
		input logic [2:0] sel
	);
		logic [`DCF_OFS_W-1:0] v;
		v = `DCF_OFS_S_0;
		if (AW < `DCF_AW_MID) begin
			unique case (sel)
				3'h0: v = `DCF_OFS_S_0;
				3'h1: v = `DCF_OFS_S_1;
				3'h2: v = `DCF_OFS_S_2;
				3'h3: v = `DCF_OFS_S_3;
				3'h4: v = `DCF_OFS_S_4;
				3'h5: v = `DCF_OFS_S_5;
				3'h6: v = `DCF_OFS_S_6;
				3'h7: v = `DCF_OFS_S_7;
			endcase
		end else if (AW < `DCF_AW_BIG) begin
			unique case (sel)
				3'h0: v = `DCF_OFS_M_0;
				3'h1: v = `DCF_OFS_M_1;
				3'h2: v = `DCF_OFS_M_2;
				3'h3: v = `DCF_OFS_M_3;
				3'h4: v = `DCF_OFS_M_4;
				3'h5: v = `DCF_OFS_M_5;
				3'h6: v = `DCF_OFS_M_6;
				3'h7: v = `DCF_OFS_M_7;
			endcase
		end else begin
			unique case (sel)
				3'h0: v = `DCF_OFS_L_0;
				3'h1: v = `DCF_OFS_L_1;
				3'h2: v = `DCF_OFS_L_2;
				3'h3: v = `DCF_OFS_L_3;
				3'h4: v = `DCF_OFS_L_4;
				3'h5: v = `DCF_OFS_L_5;
				3'h6: v = `DCF_OFS_L_6;
				3'h7: v = `DCF_OFS_L_7;
			endcase
		end
		return v;
	endfunction

	dcf_pkg::dcf_mode_t mode_reg;
	logic [AW:0] offset_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic out_valid_reg;
	logic out_valid_next;
	logic out_ready_n_reg;
	logic [`DCF_DATA_W-1:0] data_out_reg;
	logic almost_empty_n_reg;
	logic almost_full_n_reg;
	logic half_full_n_reg;
	logic fall_through_mode;
	logic ram_not_empty;
	logic ram_full;
	logic wr_fire;
	logic pop;
	logic ne_delayed;
	logic ne_stage1;
	logic [AW:0] mode_bit;
	logic [AW:0] occ;
	logic [AW:0] thr_pae;
	logic [AW:0] thr_hf;
	logic [AW:0] thr_paf;

	dcf_mem_if #(.AW(AW)) mem_bus ();

	dcf_store #(.AW(AW)) u_store (
		.clk_i(clk_i),
		.m(mem_bus.mem)
	);

	// Straps are caught while reset is held, not at power-up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= timing_mode_serial_in_i ? dcf_pkg::DCF_FALL_THROUGH :
				dcf_pkg::DCF_STANDARD;
			offset_reg <= (AW+1)'(default_offset({load_select_i,
				offset_select_1_i, offset_select_0_i}));
		end
	end

	assign fall_through_mode = (mode_reg == dcf_pkg::DCF_FALL_THROUGH);
	assign mode_bit = fall_through_mode ? ONE_C : '0;
	assign ram_not_empty = (count_reg != '0);
	// Internal full uses the live count; the pins lag by the stages
	assign ram_full = (count_reg == DEPTH_C);
	assign wr_fire = !wr_en_n_i && !ram_full;

	// Standard pops on request; fall-through refills the output word
	always_comb begin
		pop = 1'b0;
		if (!fall_through_mode) begin
			pop = !rd_en_n_i && ram_not_empty;
		end else if (ram_not_empty && ne_delayed) begin
			pop = !out_valid_reg || !rd_en_n_i;
		end
	end

	always_comb begin
		out_valid_next = out_valid_reg;
		if (!fall_through_mode) begin
			out_valid_next = 1'b0;
		end else if (pop) begin
			out_valid_next = 1'b1;
		end else if (!rd_en_n_i) begin
			out_valid_next = 1'b0;
		end
	end

	assign count_next = count_reg + (AW+1)'(wr_fire) - (AW+1)'(pop);

	assign mem_bus.wr_en = wr_fire;
	assign mem_bus.wr_addr = wr_ptr_reg;
	assign mem_bus.wr_data = data_in_i;
	assign mem_bus.rd_addr = rd_ptr_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (wr_fire) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			count_reg <= count_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_out_reg <= '0;
			out_valid_reg <= 1'b0;
			out_ready_n_reg <= 1'b1;
		end else begin
			if (pop) begin
				data_out_reg <= mem_bus.rd_data;
			end
			out_valid_reg <= out_valid_next;
			// Third stage after the two not-empty stages
			out_ready_n_reg <= !out_valid_next;
		end
	end

	// Two stages give the word time to settle before fall-through
	dcf_stage_pipe #(
		.STAGES(`DCF_NE_STAGES),
		.RESET_VAL(1'b0)
	) u_ne_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(fall_through_mode && ram_not_empty),
		.q_o(ne_delayed)
	);

	// Own copy of the first not-empty stage, so checks need no path into
	// the pipe instance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ne_stage1 <= 1'b0;
		end else begin
			ne_stage1 <= fall_through_mode && ram_not_empty;
		end
	end

	dcf_stage_pipe #(
		.STAGES(`DCF_FLAG_STAGES),
		.RESET_VAL(1'b0)
	) u_empty_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(!fall_through_mode && ram_not_empty),
		.q_o(empty_indicator_n_o)
	);

	dcf_stage_pipe #(
		.STAGES(`DCF_FLAG_STAGES),
		.RESET_VAL(1'b1)
	) u_full_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(fall_through_mode || !ram_full),
		.q_o(full_indicator_n_o)
	);

	dcf_stage_pipe #(
		.STAGES(`DCF_FLAG_STAGES),
		.RESET_VAL(1'b0)
	) u_space_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(fall_through_mode && ram_full && out_valid_reg),
		.q_o(write_space_n_o)
	);

	// Output word counts toward occupancy in fall-through mode
	assign occ = count_reg + ((fall_through_mode && out_valid_reg) ? ONE_C : '0);
	assign thr_pae = offset_reg + mode_bit;
	assign thr_hf = HALF_C + mode_bit;
	assign thr_paf = DEPTH_C - offset_reg + mode_bit;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			almost_empty_n_reg <= 1'b0;
			almost_full_n_reg <= 1'b1;
			half_full_n_reg <= 1'b1;
		end else begin
			almost_empty_n_reg <= (occ > thr_pae);
			half_full_n_reg <= !(occ > thr_hf);
			almost_full_n_reg <= !(occ >= thr_paf);
		end
	end

	assign data_out_o = data_out_reg;
	assign output_ready_n_o = out_ready_n_reg;
	assign almost_empty_indicator_n_o = almost_empty_n_reg;
	assign almost_full_indicator_n_o = almost_full_n_reg;
	assign half_full_indicator_n_o = half_full_n_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_empty_two_stage: assert property (
		!fall_through_mode |->
			empty_indicator_n_o == $past(ram_not_empty, 2)
	) else $error("empty flag not two stages behind count");

	a_full_two_stage: assert property (
		!fall_through_mode |-> full_indicator_n_o == !$past(ram_full, 2)
	) else $error("full flag not two stages behind count");

	a_write_captured: assert property (
		(wr_fire && !pop) |=> count_reg == $past(count_reg) + ONE_C
	) else $error("accepted write did not raise the count");

	a_read_ignored_empty: assert property (
		(!fall_through_mode && !ram_not_empty && !wr_fire) |=>
			$stable(data_out_reg) && !ram_not_empty
	) else $error("read from empty buffer changed state");

	a_fall_through_lat: assert property (
		(fall_through_mode && !ram_not_empty && !out_valid_reg &&
			!ne_stage1 && !ne_delayed && wr_fire) |->
			output_ready_n_o [*4] ##1 !output_ready_n_o
	) else $error("first word did not fall through in three edges");

	a_half_std_thr: assert property (
		(!fall_through_mode && occ == HALF_C + ONE_C) |=>
			!half_full_indicator_n_o
	) else $error("half-full not low at half plus one");

	a_half_fall_through_mode_thr: assert property (
		(fall_through_mode && occ == HALF_C + ONE_C) |=>
			half_full_indicator_n_o
	) else $error("half-full low too early in fall-through");

	a_pae_std_low: assert property (
		(!fall_through_mode && occ == offset_reg) |=>
			!almost_empty_indicator_n_o
	) else $error("almost-empty not low at n words");

	a_pae_fall_through_mode_low: assert property (
		(fall_through_mode && occ == offset_reg + ONE_C) |=>
			!almost_empty_indicator_n_o
	) else $error("almost-empty not low at n plus one words");

	a_space_two_stage: assert property (
		(fall_through_mode && occ == DEPTH_C + ONE_C) |-> ##2 write_space_n_o
	) else $error("write-space not high two edges after full");

	a_paf_std_thr: assert property (
		(!fall_through_mode && occ == DEPTH_C - offset_reg) |=>
			!almost_full_indicator_n_o
	) else $error("almost-full not low at depth minus m");

	c_std_full: cover property (
		!fall_through_mode && ram_full ##2 !full_indicator_n_o
	);

	c_fall_through_mode_full: cover property (
		fall_through_mode && occ == DEPTH_C + ONE_C ##2 write_space_n_o
	);

	c_std_drain: cover property (
		!fall_through_mode && pop && count_reg == ONE_C ##3
			!empty_indicator_n_o
	);

	c_fall_through_mode_last_read: cover property (
		fall_through_mode && out_valid_reg && !rd_en_n_i && !pop ##1
			output_ready_n_o
	);
endmodule

// File: dcf_peer.sv
`timescale 1ns/1ps

module dcf_peer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Commands from the bench
	input wire logic wr_go_i,
	input wire logic rd_go_i,
	// Toward the buffer
	output logic wr_en_n_o,
	output dcf_pkg::dcf_word_t data_o,
	output logic rd_en_n_o
);
	dcf_pkg::dcf_word_t seq_reg;

	// Idle bus shows the inverse, so a stale word never passes as data
	assign data_o = wr_en_n_o ? ~seq_reg : seq_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_en_n_o <= 1'b1;
			rd_en_n_o <= 1'b1;
			seq_reg <= 36'h0;
		end else begin
			wr_en_n_o <= ~wr_go_i;
			rd_en_n_o <= ~rd_go_i;
			// Counts attempts, so a dropped word leaves a gap in the sequence
			if (!wr_en_n_o) begin
				seq_reg <= seq_reg + 36'h1;
			end
		end
	end
endmodule

// File: dcf_fifo_tb.sv
`timescale 1ns/1ps

`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("unexpected %s exp %h got %h", nm, e, g); \
	end \
end

module dcf_fifo_tb;
	localparam int D = 1024;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_go = 1'b0;
	logic rd_go = 1'b0;
	logic mode = 1'b0;
	logic [2:0] sel = 3'h7;
	logic wr_en_n, rd_en_n, e_n, f_n, or_n, ws_n, ae_n, af_n, hf_n;
	dcf_pkg::dcf_word_t din, dout, last, wr_idx;
	dcf_pkg::dcf_word_t q[$];
	int occ, n;
	int err_total = 0;
	int tests_run = 0;
	int ofs[8] = '{127, 255, 511, 63, 31, 7, 15, 3};

	initial forever #2.5 clk_i = ~clk_i;

	dcf_fifo #(.AW(10)) dcf_fifo_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_en_n_i(wr_en_n),
		.data_in_i(din),
		.rd_en_n_i(rd_en_n),
		.data_out_o(dout),
		.timing_mode_serial_in_i(mode),
		.load_select_i(sel[2]),
		.offset_select_0_i(sel[0]),
		.offset_select_1_i(sel[1]),
		.empty_indicator_n_o(e_n),
		.full_indicator_n_o(f_n),
		.output_ready_n_o(or_n),
		.write_space_n_o(ws_n),
		.almost_empty_indicator_n_o(ae_n),
		.almost_full_indicator_n_o(af_n),
		.half_full_indicator_n_o(hf_n)
	);

	dcf_peer dcf_peer_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_go_i(wr_go),
		.rd_go_i(rd_go),
		.wr_en_n_o(wr_en_n),
		.data_o(din),
		.rd_en_n_o(rd_en_n)
	);

	task end_of_test;
		if (err_total == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Almost-full uses m, equal to n with default offsets
	task check;
		`CHK("empty", mode ? 1'b0 : (occ > 0), e_n)
		`CHK("full", mode | (occ < D), f_n)
		`CHK("ready", ~mode | (occ == 0), or_n)
		`CHK("space", mode & (occ > D), ws_n)
		`CHK("almost_empty", occ > n + mode, ae_n)
		`CHK("half_full", occ <= D / 2 + mode, hf_n)
		`CHK("almost_full", occ < D - n + mode, af_n)
		if (!mode || occ > 0) `CHK("data", last, dout)
	endtask

	task reset(input logic m, input logic [2:0] s);
		@(posedge clk_i);
		rst_i <= 1'b1;
		mode <= m;
		sel <= s;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		occ = 0;
		n = ofs[s];
		q.delete();
		wr_idx = 36'h0;
		last = 36'h0;
		@(posedge clk_i);
		#1;
		check;
	endtask

	// One operation, then a settle long enough for the deepest flag pipe
	task step(input logic w, input logic r);
		int lat;
		logic first;
		first = (occ == 0) && w;
		@(posedge clk_i);
		wr_go <= w;
		rd_go <= r;
		@(posedge clk_i);
		wr_go <= 1'b0;
		rd_go <= 1'b0;
		@(posedge clk_i);
		lat = 0;
		for (int k = 1; k <= 6; k++) begin
			@(posedge clk_i);
			#1;
			if (lat == 0 && (mode ? !or_n : e_n)) lat = k;
		end
		if (first) `CHK("latency", 2 + mode, lat)
		if (r && occ > 0) begin
			last = q.pop_front();
			occ--;
		end
		if (w && occ < D + mode) begin
			q.push_back(wr_idx);
			occ++;
		end
		if (w) wr_idx++;
		if (mode && occ > 0) last = q[0];
		check;
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		err_total++;
		end_of_test;
	end

	initial begin
		for (int s = 0; s < 8; s++) begin
			reset(1'b0, s[2:0]);
			repeat (ofs[s] + 2) step(1'b1, 1'b0);
		end
		for (int m = 0; m < 2; m++) begin
			reset(m[0], 3'h7);
			step(1'b0, 1'b1);
			// Writes past capacity must be dropped: two in standard mode, one in fall-through
			repeat (D + 2) step(1'b1, 1'b0);
			step(1'b0, 1'b1);
			repeat (3) step(1'b1, 1'b1);
			// Drain past empty so trailing reads are refused
			repeat (D + 2) step(1'b0, 1'b1);
		end
		end_of_test;
	end
endmodule
